// [lcd_scan_pkg.sv]
/*
 * Shared constants and types for the LCD scan and display memory port.
 * Assumes a 100 MHz system clock; all pin timing is counted in its cycles.
 */
package lcd_scan_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAIN_PULSES = 16;

    // Least strobe width on the memory port, rounded up to cycles
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    // Least half period of the column shift clock
    localparam int COLUMN_SHIFT_CLK_HALF_NS = 20;
    localparam int COLUMN_SHIFT_CLK_HALF_CYCLES = (COLUMN_SHIFT_CLK_HALF_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    // Least width of the line latch pulse
    localparam int LATCH_NS = 60;
    localparam int LATCH_CYCLES = (LATCH_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;

    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYCLES - 1);
    localparam logic [3:0] COLUMN_SHIFT_CLK_HALF_LAST = 4'(COLUMN_SHIFT_CLK_HALF_CYCLES - 1);
    localparam logic [3:0] LATCH_LAST = 4'(LATCH_CYCLES - 1);
    localparam logic [3:0] CHAIN_LAST = 4'(CHAIN_PULSES - 1);

    localparam logic [15:0] FETCH_ADDR_RESET = 16'h0000;
    localparam logic ROW_DISABLE_RESET = 1'h1;
    localparam logic STROBE_IDLE = 1'h1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_req_t;

    typedef enum logic [1:0] {
        MEM_IDLE = 2'b00,
        MEM_READ = 2'b01,
        MEM_WRITE = 2'b10
    } mem_state_t;

    typedef enum logic [2:0] {
        SC_FETCH = 3'b000,
        SC_RISE = 3'b001,
        SC_HIGH = 3'b010,
        SC_LOW = 3'b011,
        SC_LATCH = 3'b100,
        SC_SLEEP = 3'b101
    } scan_state_t;

endpackage : lcd_scan_pkg

// [byte_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_SLOT) ? '0 :
                    wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_SLOT) ? '0 :
                    rd_ptr_reg + AW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + (AW + 1)'(1);
        end else if (pop && !push) begin
            count_reg <= count_reg - (AW + 1)'(1);
        end
    end

endmodule : byte_fifo

// [lcd_scan_and_display_memory_port.sv]
/*
 * Display memory port and LCD column/row drive signal generator.
 * Assumes static memory and driver chips on the pins; same-clock commands.
 */
// Operation
// - 16-bit address; CG fetch low nibble is row
// - 8-bit bidirectional tri-state memory data bus
// - Data bus driven only while a strobe low
// - Active-low memory write strobe output
// - Active-low memory read strobe output
// - Active-low select; high puts memory in standby
// - Column data leaves four bits at a time
// - Nibble stable across column clock falling edge
// - Column clock halts from latch to next line
// - Chain clock falling edges advance enable cascade
// - Cascade moves to next chip every 16 pulses
// - Latch pulse loads column latches, shifts rows
// - Latch pulse falls exactly once per line
// - Waveform period picked from two by config
// - Row clock falling edge captures row data
// - Row data high during last line of frame
// - Power-down output high while drive active
// - Sleep drops power-down within two frames
`timescale 1ns/1ps
module lcd_scan_and_display_memory_port #(
    parameter int BYTES_PER_LINE = 40,
    parameter int LINES_PER_FRAME = 64,
    parameter int WF_LINES = 13,
    parameter int CHIP_SEL_W = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sleep_cmd,
    input wire logic wake_cmd,
    input wire logic wf_period_sel,
    input wire logic cg_fetch_mode,
    input wire logic wr_req_valid,
    output logic wr_req_ready,
    input wire lcd_scan_pkg::mem_wr_req_t wr_req,
    output logic [lcd_scan_pkg::ADDR_W-1:0] disp_mem_addr,
    input wire logic [lcd_scan_pkg::DATA_W-1:0] disp_mem_data_in,
    output logic [lcd_scan_pkg::DATA_W-1:0] disp_mem_data_out,
    output logic disp_mem_data_oe,
    output logic mem_write_n,
    output logic mem_read_n,
    output logic mem_standby_n,
    output logic [lcd_scan_pkg::NIB_W-1:0] column_data_nibble,
    output logic column_shift_clk,
    output logic chain_enable_clk,
    output logic [CHIP_SEL_W-1:0] chain_chip_index,
    output logic line_latch_pulse,
    output logic ac_drive_waveform,
    output logic row_shift_clk,
    output logic row_scan_data,
    output logic row_drive_disable
);
    import lcd_scan_pkg::*;
    localparam logic [15:0] LINE_BYTES_LAST = 16'(BYTES_PER_LINE - 1);
    localparam logic [15:0] LINE_NIBS_LAST = 16'(2 * BYTES_PER_LINE - 1);
    localparam logic [15:0] FRAME_LINES_LAST = 16'(LINES_PER_FRAME - 1);
    localparam logic [15:0] WF_LINES_LAST = 16'(WF_LINES - 1);
    mem_state_t mem_state_reg;
    logic [3:0] strobe_cnt_reg;
    logic [ADDR_W-1:0] fetch_addr_reg;
    logic [15:0] fetch_byte_reg;
    logic [15:0] fetch_line_reg;
    logic [DATA_W-1:0] rd_sync1_reg;
    logic [DATA_W-1:0] rd_sync2_reg;
    logic fifo_in_valid_reg;
    logic [DATA_W-1:0] fifo_in_data_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    scan_state_t scan_state_reg;
    logic [3:0] phase_cnt_reg;
    logic [DATA_W-1:0] byte_reg;
    logic nib_hi_reg;
    logic [15:0] nib_idx_reg;
    logic [15:0] line_idx_reg;
    logic [15:0] wf_line_cnt_reg;
    logic [3:0] chain_cnt_reg;
    logic sleep_pend_reg;
    logic frame_end;
    assign frame_end = (line_idx_reg == FRAME_LINES_LAST);
    // Pixel bytes wait here so fetch and scan run at their own pace
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(fifo_in_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(scan_state_reg == SC_FETCH),
        .out_data(fifo_out_data)
    );
    // Read data passes two flops before use
    always_ff @(posedge mclk) begin
        rd_sync1_reg <= disp_mem_data_in;
        rd_sync2_reg <= rd_sync1_reg;
    end
    // Memory cycle sequencer; host writes win over display fetch
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mem_state_reg <= MEM_IDLE;
            wr_req_ready <= 1'b1;
            strobe_cnt_reg <= '0;
            disp_mem_addr <= FETCH_ADDR_RESET;
            disp_mem_data_out <= '0;
            disp_mem_data_oe <= 1'b0;
            mem_write_n <= STROBE_IDLE;
            mem_read_n <= STROBE_IDLE;
            mem_standby_n <= STROBE_IDLE;
            fifo_in_valid_reg <= 1'b0;
            fifo_in_data_reg <= '0;
        end else begin
            fifo_in_valid_reg <= 1'b0;
            wr_req_ready <= 1'b0;
            case (mem_state_reg)
                MEM_IDLE: begin
                    strobe_cnt_reg <= STROBE_LAST;
                    wr_req_ready <= fifo_in_valid_reg ||
                        !(wr_req_valid || fifo_in_ready);
                    if (wr_req_valid && !fifo_in_valid_reg) begin
                        mem_state_reg <= MEM_WRITE;
                        disp_mem_addr <= wr_req.addr;
                        disp_mem_data_out <= wr_req.data;
                        mem_write_n <= 1'b0;
                        mem_standby_n <= 1'b0;
                        disp_mem_data_oe <= 1'b1;
                    end else if (fifo_in_ready && !fifo_in_valid_reg) begin
                        mem_state_reg <= MEM_READ;
                        mem_read_n <= 1'b0;
                        mem_standby_n <= 1'b0;
                        disp_mem_addr <= cg_fetch_mode ?
                            {fetch_addr_reg[11:0], fetch_line_reg[3:0]} :
                            fetch_addr_reg;
                    end
                end
                MEM_WRITE: begin
                    if (strobe_cnt_reg == '0) begin
                        mem_state_reg <= MEM_IDLE;
                        mem_write_n <= STROBE_IDLE;
                        wr_req_ready <= 1'b1;
                        mem_standby_n <= STROBE_IDLE;
                        disp_mem_data_oe <= 1'b0;
                    end else begin
                        strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
                    end
                end
                MEM_READ: begin
                    // Sync delay is covered because the strobe spans it
                    if (strobe_cnt_reg == '0) begin
                        mem_state_reg <= MEM_IDLE;
                        mem_read_n <= STROBE_IDLE;
                        mem_standby_n <= STROBE_IDLE;
                        fifo_in_valid_reg <= 1'b1;
                        fifo_in_data_reg <= rd_sync2_reg;
                    end else begin
                        strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
                    end
                end
                default: mem_state_reg <= MEM_IDLE;
            endcase
        end
    end
    // Fetch address and line tracking, wraps at frame end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fetch_addr_reg <= FETCH_ADDR_RESET;
            fetch_byte_reg <= '0;
            fetch_line_reg <= '0;
        end else if (mem_state_reg == MEM_READ && strobe_cnt_reg == '0) begin
            fetch_addr_reg <= fetch_addr_reg + 16'h1;
            fetch_byte_reg <= fetch_byte_reg + 16'h1;
            if (fetch_byte_reg == LINE_BYTES_LAST) begin
                fetch_byte_reg <= '0;
                fetch_line_reg <= fetch_line_reg + 16'h1;
                if (fetch_line_reg == FRAME_LINES_LAST) begin
                    fetch_line_reg <= '0;
                    fetch_addr_reg <= FETCH_ADDR_RESET;
                end
            end
        end
    end
    // Column scan sequencer
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scan_state_reg <= SC_FETCH;
            phase_cnt_reg <= '0;
            byte_reg <= '0;
            nib_hi_reg <= 1'b1;
            nib_idx_reg <= '0;
            column_data_nibble <= '0;
            column_shift_clk <= 1'b0;
            chain_enable_clk <= 1'b0;
            line_latch_pulse <= 1'b0;
            row_shift_clk <= 1'b0;
            row_drive_disable <= ROW_DISABLE_RESET;
        end else begin
            case (scan_state_reg)
                SC_FETCH: begin
                    if (fifo_out_valid) begin
                        byte_reg <= fifo_out_data;
                        nib_hi_reg <= 1'b1;
                        scan_state_reg <= SC_RISE;
                    end
                end
                SC_RISE: begin
                    // nibble on rising edge, four bits
                    column_shift_clk <= 1'b1;
                    chain_enable_clk <= 1'b1;
                    column_data_nibble <= nib_hi_reg ? byte_reg[7:4] :
                        byte_reg[3:0];
                    phase_cnt_reg <= COLUMN_SHIFT_CLK_HALF_LAST;
                    scan_state_reg <= SC_HIGH;
                end
                SC_HIGH: begin
                    if (phase_cnt_reg == '0) begin
                        column_shift_clk <= 1'b0;
                        chain_enable_clk <= 1'b0;
                        phase_cnt_reg <= COLUMN_SHIFT_CLK_HALF_LAST;
                        scan_state_reg <= SC_LOW;
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg - 4'h1;
                    end
                end
                SC_LOW: begin
                    if (phase_cnt_reg != '0) begin
                        phase_cnt_reg <= phase_cnt_reg - 4'h1;
                    end else if (nib_idx_reg == LINE_NIBS_LAST) begin
                        // latch pulse doubles as row clock
                        line_latch_pulse <= 1'b1;
                        row_shift_clk <= 1'b1;
                        nib_idx_reg <= '0;
                        phase_cnt_reg <= LATCH_LAST;
                        scan_state_reg <= SC_LATCH;
                    end else begin
                        nib_idx_reg <= nib_idx_reg + 16'h1;
                        nib_hi_reg <= 1'b0;
                        scan_state_reg <= nib_hi_reg ? SC_RISE : SC_FETCH;
                    end
                end
                SC_LATCH: begin
                    if (phase_cnt_reg == '0) begin
                        // one falling edge per line, row capture
                        line_latch_pulse <= 1'b0;
                        row_shift_clk <= 1'b0;
                        if (frame_end && sleep_pend_reg) begin
                            row_drive_disable <= 1'b0;
                            scan_state_reg <= SC_SLEEP;
                        end else begin
                            scan_state_reg <= SC_FETCH;
                        end
                    end else begin
                        phase_cnt_reg <= phase_cnt_reg - 4'h1;
                    end
                end
                SC_SLEEP: begin
                    if (wake_cmd) begin
                        row_drive_disable <= 1'b1;
                        scan_state_reg <= SC_FETCH;
                    end
                end
                default: scan_state_reg <= SC_FETCH;
            endcase
        end
    end

    // Sleep request is sticky; a new request beats the clear
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sleep_pend_reg <= 1'b0;
        end else if (sleep_cmd) begin
            sleep_pend_reg <= 1'b1;
        end else if (scan_state_reg == SC_SLEEP) begin
            sleep_pend_reg <= 1'b0;
        end
    end

    // next chip every 16 chain pulses
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            chain_cnt_reg <= '0;
            chain_chip_index <= '0;
        end else if (scan_state_reg == SC_LATCH) begin
            chain_cnt_reg <= '0;
            chain_chip_index <= '0;
        end else if (scan_state_reg == SC_HIGH && phase_cnt_reg == '0) begin
            chain_cnt_reg <= chain_cnt_reg + 4'h1;
            if (chain_cnt_reg == CHAIN_LAST) begin
                chain_chip_index <= chain_chip_index + CHIP_SEL_W'(1);
            end
        end
    end

    // Line count, row data and AC waveform update as each latch ends
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            line_idx_reg <= '0;
            wf_line_cnt_reg <= '0;
            row_scan_data <= (LINES_PER_FRAME == 1);
            ac_drive_waveform <= 1'b0;
        end else if (scan_state_reg == SC_LATCH && phase_cnt_reg == '0) begin
            line_idx_reg <= frame_end ? '0 : line_idx_reg + 16'h1;
            row_scan_data <= frame_end ? (LINES_PER_FRAME == 1) :
                (line_idx_reg + 16'h1 == FRAME_LINES_LAST);
            if (wf_period_sel) begin
                if (wf_line_cnt_reg == WF_LINES_LAST) begin
                    wf_line_cnt_reg <= '0;
                    ac_drive_waveform <= ~ac_drive_waveform;
                end else begin
                    wf_line_cnt_reg <= wf_line_cnt_reg + 16'h1;
                end
            end else begin
                wf_line_cnt_reg <= '0;
                if (frame_end) begin
                    ac_drive_waveform <= ~ac_drive_waveform;
                end
            end
        end
    end

endmodule : lcd_scan_and_display_memory_port

// [lcd_scan_sva.sv]
/*
 * Port checker for the LCD scan and display memory port.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module lcd_scan_sva #(
    parameter int CHIP_SEL_W = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [lcd_scan_pkg::ADDR_W-1:0] disp_mem_addr,
    input wire logic disp_mem_data_oe,
    input wire logic mem_write_n,
    input wire logic mem_read_n,
    input wire logic mem_standby_n,
    input wire logic [lcd_scan_pkg::NIB_W-1:0] column_data_nibble,
    input wire logic column_shift_clk,
    input wire logic chain_enable_clk,
    input wire logic [CHIP_SEL_W-1:0] chain_chip_index,
    input wire logic line_latch_pulse,
    input wire logic row_shift_clk,
    input wire logic row_drive_disable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_low;
        (!mem_write_n)[*4] ##1 mem_write_n;
    endsequence
    sequence s_rd_hold;
        ($stable(disp_mem_addr) && !mem_read_n)[*3] ##1 mem_read_n;
    endsequence

    property p_wr_strobe;
        $fell(mem_write_n) |-> s_wr_low;
    endproperty
    property p_rd_strobe;
        $fell(mem_read_n) |=> s_rd_hold;
    endproperty
    property p_oe_write;
        disp_mem_data_oe |-> !mem_write_n && mem_read_n;
    endproperty
    property p_standby;
        mem_standby_n == (mem_read_n && mem_write_n);
    endproperty
    property p_nib_stable;
        $fell(column_shift_clk) |-> $stable(column_data_nibble);
    endproperty
    property p_nib_rise;
        !$stable(column_data_nibble) |-> $rose(column_shift_clk);
    endproperty
    property p_halt;
        line_latch_pulse |-> !column_shift_clk;
    endproperty
    property p_latch_width;
        $rose(line_latch_pulse) |-> line_latch_pulse[*6] ##1 !line_latch_pulse;
    endproperty
    property p_row_clk;
        row_shift_clk == line_latch_pulse;
    endproperty
    property p_chain;
        chain_enable_clk == column_shift_clk;
    endproperty
    property p_chain_step;
        !$stable(chain_chip_index) && chain_chip_index != '0
            |-> chain_chip_index == $past(chain_chip_index) + 1'b1;
    endproperty
    property p_drive_on;
        column_shift_clk |-> row_drive_disable;
    endproperty

    a_wr_strobe: assert property (p_wr_strobe)
        else $error("write strobe width wrong");
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe or address not held");
    a_oe_write: assert property (p_oe_write)
        else $error("data bus driven outside write");
    a_standby: assert property (p_standby)
        else $error("select does not follow strobes");
    a_nib_stable: assert property (p_nib_stable)
        else $error("nibble moved at column clock fall");
    a_nib_rise: assert property (p_nib_rise)
        else $error("nibble moved off column clock rise");
    a_halt: assert property (p_halt)
        else $error("column clock high during latch");
    a_latch_width: assert property (p_latch_width)
        else $error("latch pulse width wrong");
    a_row_clk: assert property (p_row_clk)
        else $error("row clock differs from latch");
    a_chain: assert property (p_chain)
        else $error("chain clock differs from column clock");
    a_chain_step: assert property (p_chain_step)
        else $error("chip index skipped");
    a_drive_on: assert property (p_drive_on)
        else $error("drive active while powered down");
endmodule : lcd_scan_sva

bind lcd_scan_and_display_memory_port lcd_scan_sva #(
    .CHIP_SEL_W(CHIP_SEL_W)
) u_sva (
    .mclk(mclk), .rst_b(rst_b), .disp_mem_addr(disp_mem_addr),
    .disp_mem_data_oe(disp_mem_data_oe), .mem_write_n(mem_write_n),
    .mem_read_n(mem_read_n), .mem_standby_n(mem_standby_n),
    .column_data_nibble(column_data_nibble),
    .column_shift_clk(column_shift_clk), .chain_enable_clk(chain_enable_clk),
    .chain_chip_index(chain_chip_index), .line_latch_pulse(line_latch_pulse),
    .row_shift_clk(row_shift_clk), .row_drive_disable(row_drive_disable)
);

// [disp_mem_model.sv]
/*
 * Static memory model on the display memory pins.
 * Assumes the controller owns all strobes; answers reads at once.
 */
`timescale 1ns/1ps
module disp_mem_model (
    input wire logic mclk,
    input wire logic [lcd_scan_pkg::ADDR_W-1:0] disp_mem_addr,
    input wire logic [lcd_scan_pkg::DATA_W-1:0] disp_mem_data_out,
    input wire logic disp_mem_data_oe,
    input wire logic mem_write_n,
    input wire logic mem_read_n,
    input wire logic mem_standby_n,
    output logic [lcd_scan_pkg::DATA_W-1:0] disp_mem_data_in
);
    import lcd_scan_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] last_reg = 8'h00;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 29 + 53);
        end
    end
    // Released bus shows the inverse of the last value, never a held copy
    always_comb begin
        if (!mem_read_n && !mem_standby_n) begin
            disp_mem_data_in = mem[disp_mem_addr[7:0]];
        end else begin
            disp_mem_data_in = ~last_reg;
        end
    end
    always @(posedge mclk) begin
        if (!mem_read_n) begin
            last_reg <= mem[disp_mem_addr[7:0]];
        end
        if (!mem_write_n && !mem_standby_n && disp_mem_data_oe) begin
            mem[disp_mem_addr[7:0]] <= disp_mem_data_out;
        end
    end
endmodule : disp_mem_model

// [lcd_scan_and_display_memory_port_bench.sv]
/*
 * Self-checking bench for the LCD scan and display memory port.
 * Assumes the memory model on the far side; small line and frame sizes.
 */
`timescale 1ns/1ps
module lcd_scan_and_display_memory_port_bench;
    import lcd_scan_pkg::*;
    localparam int BYTES = 10;
    localparam int LINES = 3;
    logic mclk = 0, rst_b = 0, sleep_cmd = 0, wake_cmd = 0;
    logic wf_period_sel = 0, cg_fetch_mode = 0, wr_req_valid = 0;
    logic wr_req_ready, disp_mem_data_oe, mem_write_n, mem_read_n;
    logic mem_standby_n, column_shift_clk, chain_enable_clk, line_latch_pulse;
    logic ac_drive_waveform, row_shift_clk, row_scan_data, row_drive_disable;
    mem_wr_req_t wr_req = '0;
    logic [ADDR_W-1:0] disp_mem_addr;
    logic [DATA_W-1:0] data_in, data_out;
    logic [NIB_W-1:0] column_data_nibble;
    logic [3:0] nib_q[$];
    logic clk_prev = 0, lat_prev = 0, wf_prev = 0;
    int mismatches = 0, tests_run = 0, lat_falls = 0, wf_tog = 0, cyc = 0;

    lcd_scan_and_display_memory_port #(.BYTES_PER_LINE(BYTES),
        .LINES_PER_FRAME(LINES), .WF_LINES(2), .CHIP_SEL_W(4)) dut (
        .mclk(mclk), .rst_b(rst_b), .sleep_cmd(sleep_cmd),
        .wake_cmd(wake_cmd), .wf_period_sel(wf_period_sel),
        .cg_fetch_mode(cg_fetch_mode), .wr_req_valid(wr_req_valid),
        .wr_req_ready(wr_req_ready), .wr_req(wr_req),
        .disp_mem_addr(disp_mem_addr), .disp_mem_data_in(data_in),
        .disp_mem_data_out(data_out), .disp_mem_data_oe(disp_mem_data_oe),
        .mem_write_n(mem_write_n), .mem_read_n(mem_read_n),
        .mem_standby_n(mem_standby_n), .column_data_nibble(column_data_nibble),
        .column_shift_clk(column_shift_clk), .chain_enable_clk(chain_enable_clk),
        .chain_chip_index(), .line_latch_pulse(line_latch_pulse),
        .ac_drive_waveform(ac_drive_waveform), .row_shift_clk(row_shift_clk),
        .row_scan_data(row_scan_data), .row_drive_disable(row_drive_disable));
    disp_mem_model u_mem (.mclk(mclk), .disp_mem_addr(disp_mem_addr),
        .disp_mem_data_out(data_out), .disp_mem_data_oe(disp_mem_data_oe),
        .mem_write_n(mem_write_n), .mem_read_n(mem_read_n),
        .mem_standby_n(mem_standby_n), .disp_mem_data_in(data_in));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Settled values are sampled on the falling edge
    always @(negedge mclk) begin
        if (rst_b && clk_prev && !column_shift_clk) begin
            nib_q.push_back(column_data_nibble);
        end
        if (rst_b && lat_prev && !line_latch_pulse) begin
            lat_falls++;
        end
        if (rst_b && wf_prev !== ac_drive_waveform) begin
            wf_tog++;
        end
        clk_prev = column_shift_clk;
        lat_prev = line_latch_pulse;
        wf_prev = ac_drive_waveform;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic wait_lat(input int n);
        for (int i = 0; i < 3000 && lat_falls < n; i++) @(negedge mclk);
    endtask : wait_lat

    task automatic t_reset;
        @(negedge mclk);
        check({mem_write_n, mem_read_n, mem_standby_n, disp_mem_data_oe}, 16'hE);
        check({15'h0, row_drive_disable}, 16'h1);
    endtask : t_reset

    task automatic t_line;
        logic [7:0] b;
        for (int i = 0; i < 5000 && nib_q.size() < 2 * BYTES; i++) @(negedge mclk);
        for (int i = 0; i < BYTES; i++) begin
            b = 8'(i * 29 + 53);
            check({12'h0, nib_q[2 * i]}, {12'h0, b[7:4]});
            check({12'h0, nib_q[2 * i + 1]}, {12'h0, b[3:0]});
        end
    endtask : t_line

    task automatic t_frame;
        int n0, k;
        wait_lat(1);
        n0 = nib_q.size();
        k = lat_falls;
        for (int j = 1; j <= LINES; j++) begin
            wait_lat(k + j);
            check({15'h0, row_scan_data}, {15'h0, ((k + j) % LINES) == 2});
            check(16'(nib_q.size() - n0), 16'(2 * BYTES * j));
        end
    endtask : t_frame

    task automatic t_wf(input logic sel, input int exp);
        int k;
        @(negedge mclk);
        wf_period_sel = sel;
        wait_lat(lat_falls + 1);
        k = wf_tog;
        wait_lat(lat_falls + 6);
        check(16'(wf_tog - k), 16'(exp));
    endtask : t_wf

    task automatic t_write;
        @(negedge mclk);
        wr_req_valid = 1;
        wr_req = '{addr: 16'h00C3, data: 8'h5A};
        for (int i = 0; i < 200 && !wr_req_ready; i++) @(negedge mclk);
        @(negedge mclk);
        wr_req_valid = 0;
        repeat (8) @(negedge mclk);
        check({8'h0, u_mem.mem[8'hC3]}, 16'h005A);
    endtask : t_write

    task automatic t_cg;
        @(negedge mclk);
        cg_fetch_mode = 1;
        // A read already running still has the plain address
        @(negedge mem_read_n);
        @(negedge mclk);
        check({15'h0, disp_mem_addr[3:0] < 4'(LINES)}, 16'h1);
        cg_fetch_mode = 0;
    endtask : t_cg

    task automatic t_sleep;
        int n0;
        @(negedge mclk);
        sleep_cmd = 1;
        @(negedge mclk);
        sleep_cmd = 0;
        // Sleep only bites at frame end, so allow two full frames
        for (int i = 0; i < 2000 && row_drive_disable; i++) @(negedge mclk);
        check({15'h0, row_drive_disable}, 16'h0);
        n0 = nib_q.size();
        repeat (300) @(negedge mclk);
        check(16'(nib_q.size() - n0), 16'h0);
        wake_cmd = 1;
        @(negedge mclk);
        wake_cmd = 0;
        for (int i = 0; i < 2000 && nib_q.size() == n0; i++) @(negedge mclk);
        check({15'h0, row_drive_disable}, 16'h1);
    endtask : t_sleep

    initial begin
        repeat (5) @(negedge mclk);
        t_reset();
        rst_b = 1;
        t_line();
        t_frame();
        t_wf(1'b1, 3);
        t_wf(1'b0, 2);
        t_write();
        t_cg();
        t_sleep();
        end_sim();
    end
endmodule : lcd_scan_and_display_memory_port_bench
